// >>> pmbus_fault_status_bank.sv
// fault and warning status register bank answering status read commands
`timescale 1ns/1ps
`include "fault_status_params.svh"

// Functional notes
// - summary word read returns two bytes summarising all faults and warnings
// - word low byte equals the summary byte at the same moment
// - summary bit 6 set while converter disabled; bit 7 unused
// - summary bit 5 reports output overvoltage fault
// - summary bit 4 reports output overcurrent fault
// - summary bit 3 reports input undervoltage fault
// - summary bit 2 set by any temperature fault or warning
// - summary bit 1 set by any communication, memory or logic fault
// - summary bit 0 covers other faults such as undervoltage or current warning
// - high byte bit 7 set by any output voltage flag
// - high byte bit 6 for output current only, never power
// - high byte bit 4 reports internal thermal shutdown
// - high byte bit 3 shows power good; bits 5,2,1,0 unused
// - voltage byte bit 7 on output overvoltage
// - voltage byte bit 4 on output undervoltage; others zero
// - current byte bit 7 fault, bit 5 warning; others zero
// - thermal byte bit 7 fault, bit 6 warning; others zero
// - comm byte bits 7,6,5,4,1 as command, data, PEC, memory, other
// - comm bit 7 set on invalid or unsupported command code
// - command 78h returns the summary byte
// - inconsistent limit write sets invalid data and comm summary bit
// - PEC failure sets comm byte packet error bit
// - internal memory fault sets comm byte memory bit
module pmbus_fault_status_bank
  import fault_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire read_req_t readReq,
  input wire logic writeStrobe,
  input wire logic clearFaults,
  input wire fault_events_t events,
  input wire logic convEnabled,
  input wire logic powerGood,
  output logic [15:0] readData,
  output logic readValid,
  output logic readWord,
  output logic cmdUnknown
);

  // ---------------------------------------------------------------
  // detail flag bytes
  // ---------------------------------------------------------------
  logic [7:0] voutFlags;
  logic [7:0] ioutFlags;
  logic [7:0] tempFlags;
  logic [7:0] commFlags;
  logic [7:0] miscFlags;
  logic [7:0] voutSet;
  logic [7:0] ioutSet;
  logic [7:0] tempSet;
  logic [7:0] commSet;
  logic [7:0] miscSet;
  logic badCmdSeen;

  function automatic logic isKnownCmd(input logic [7:0] c);
    isKnownCmd = (c == `CMD_SUMMARY_BYTE) || (c == `CMD_SUMMARY_WORD) ||
                 (c == `CMD_VOUT_FLAGS) || (c == `CMD_IOUT_FLAGS) ||
                 (c == `CMD_TEMP_FLAGS) || (c == `CMD_COMM_FLAGS);
  endfunction : isKnownCmd

  assign badCmdSeen = readReq.valid && !isKnownCmd(readReq.cmd);

  always_comb begin
    voutSet = 8'h00;
    ioutSet = 8'h00;
    tempSet = 8'h00;
    commSet = 8'h00;
    miscSet = 8'h00;
    voutSet[`VO_OV] = events.outOv;
    voutSet[`VO_UV] = events.outUv;
    ioutSet[`IO_FAULT] = events.ocFault;
    ioutSet[`IO_WARN] = events.ocWarn;
    tempSet[`TF_FAULT] = events.otFault;
    tempSet[`TF_WARN] = events.otWarn;
    commSet[`CF_CMD] = events.badCmd | badCmdSeen;
    commSet[`CF_DATA] = events.badData;
    commSet[`CF_PEC] = events.pecFail;
    commSet[`CF_MEM] = events.memFault;
    commSet[`CF_OTHER] = events.commOther;
    miscSet[0] = events.vinUv;
    miscSet[1] = events.dieOverheat;
  end

  // writes never reach these: only clearFaults or rst empties them
  sticky_flag_byte u_vout (
    .clk(clk), .rst(rst), .setMask(voutSet), .supported(8'h90),
    .clear(clearFaults), .flags(voutFlags)
  );
  sticky_flag_byte u_iout (
    .clk(clk), .rst(rst), .setMask(ioutSet), .supported(8'hA0),
    .clear(clearFaults), .flags(ioutFlags)
  );
  sticky_flag_byte u_temp (
    .clk(clk), .rst(rst), .setMask(tempSet), .supported(8'hC0),
    .clear(clearFaults), .flags(tempFlags)
  );
  sticky_flag_byte u_comm (
    .clk(clk), .rst(rst), .setMask(commSet), .supported(8'hF2),
    .clear(clearFaults), .flags(commFlags)
  );
  sticky_flag_byte u_misc (
    .clk(clk), .rst(rst), .setMask(miscSet), .supported(8'h03),
    .clear(clearFaults), .flags(miscFlags)
  );

  // ---------------------------------------------------------------
  // summary
  // ---------------------------------------------------------------
  logic [7:0] summaryLow;
  logic [7:0] summaryHigh;

  // combinational summary so byte and word reads cannot disagree
  summary_encoder u_sum (
    .voutFlags(voutFlags),
    .ioutFlags(ioutFlags),
    .tempFlags(tempFlags),
    .commFlags(commFlags),
    .convOff(!convEnabled),
    .powerGood(powerGood),
    .vinUvFlag(miscFlags[0]),
    .vendorFlag(miscFlags[1]),
    .summaryLow(summaryLow),
    .summaryHigh(summaryHigh)
  );

  // ---------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------
  read_state_t state;
  read_state_t next_state;
  logic [15:0] next_readData;
  logic next_readValid;
  logic next_readWord;
  logic next_cmdUnknown;

  always_comb begin
    next_state = IDLE;
    next_readData = 16'h0000;
    next_readValid = 1'b0;
    next_readWord = 1'b0;
    next_cmdUnknown = 1'b0;
    unique case (state)
      IDLE, ANSWER: begin
        if (readReq.valid) begin
          next_state = ANSWER;
          next_readValid = 1'b1;
          unique case (readReq.cmd)
            `CMD_SUMMARY_BYTE: next_readData = {8'h00, summaryLow};
            `CMD_SUMMARY_WORD: begin
              next_readData = {summaryHigh, summaryLow};
              next_readWord = 1'b1;
            end
            `CMD_VOUT_FLAGS: next_readData = {8'h00, voutFlags};
            `CMD_IOUT_FLAGS: next_readData = {8'h00, ioutFlags};
            `CMD_TEMP_FLAGS: next_readData = {8'h00, tempFlags};
            `CMD_COMM_FLAGS: next_readData = {8'h00, commFlags};
            default: next_cmdUnknown = 1'b1;
          endcase
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
      readData <= 16'h0000;
      readValid <= 1'b0;
      readWord <= 1'b0;
      cmdUnknown <= 1'b0;
    end else begin
      state <= next_state;
      readData <= next_readData;
      readValid <= next_readValid;
      readWord <= next_readWord;
      cmdUnknown <= next_cmdUnknown;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_word_low_match: assert property (readReq.valid && readReq.cmd == `CMD_SUMMARY_WORD
    |=> readWord && readData[7:0] == $past(summaryLow))
    else $error("word low byte differs from summary byte");
  chk_off_bit: assert property (!convEnabled |-> summaryLow[`SB_OFF])
    else $error("off bit clear while converter disabled");
  chk_ov_sticky: assert property (events.outOv && !clearFaults
    |=> voutFlags[`VO_OV] && summaryLow[`SB_OV])
    else $error("overvoltage not latched");
  chk_oc_fault: assert property (events.ocFault |=> summaryLow[`SB_OC])
    else $error("overcurrent summary missing");
  chk_temp_or: assert property (summaryLow[`SB_TEMP] == (|tempFlags))
    else $error("temperature summary mismatch");
  chk_cml_or: assert property (summaryLow[`SB_CML] == (|commFlags))
    else $error("comm summary mismatch");
  chk_bad_cmd: assert property (badCmdSeen |=> cmdUnknown && commFlags[`CF_CMD])
    else $error("unknown command not flagged");
  chk_unused_zero: assert property (summaryLow[7] == 1'b0 && summaryHigh[5] == 1'b0
    && summaryHigh[2:0] == 3'b000 && voutFlags[6:5] == 2'b00)
    else $error("unused bit set");
  chk_read_once: assert property (readValid && !$past(readReq.valid) |-> 1'b0)
    else $error("answer without request");
  // a write with no event, clear or bad command must leave the vout, iout, temp and comm bytes as they were
  chk_write_ignored: assert property (writeStrobe && !clearFaults && events == '0 && !badCmdSeen
    |=> voutFlags == $past(voutFlags) && ioutFlags == $past(ioutFlags)
    && tempFlags == $past(tempFlags) && commFlags == $past(commFlags))
    else $error("write changed status flags");

  cov_word_read: cover property (readReq.valid && readReq.cmd == `CMD_SUMMARY_WORD);
  cov_clear_set: cover property (clearFaults && events.outOv);
  cov_bad_cmd: cover property (badCmdSeen);

endmodule : pmbus_fault_status_bank

// >>> fault_status_params.svh
// constants for the fault status register bank
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

// command codes
`define CMD_SUMMARY_BYTE 8'h78
`define CMD_SUMMARY_WORD 8'h79
`define CMD_VOUT_FLAGS 8'h7A
`define CMD_IOUT_FLAGS 8'h7B
`define CMD_TEMP_FLAGS 8'h7D
`define CMD_COMM_FLAGS 8'h7E

// summary byte bit positions
`define SB_OFF 6
`define SB_OV 5
`define SB_OC 4
`define SB_INPUT_UNDERVOLTAGE_FLAG 3
`define SB_TEMP 2
`define SB_CML 1
`define SB_OTHER 0

// summary high byte bit positions
`define SH_VOUT 7
`define SH_IOUT 6
`define SH_VENDOR 4
`define SH_PGOOD 3

// detail byte bit positions
`define VO_OV 7
`define VO_UV 4
`define IO_FAULT 7
`define IO_WARN 5
`define TF_FAULT 7
`define TF_WARN 6
`define CF_CMD 7
`define CF_DATA 6
`define CF_PEC 5
`define CF_MEM 4
`define CF_OTHER 1

// reset values
`define FLAGS_RESET 8'h00

`endif

// >>> fault_status_pkg.sv
// types shared by the fault status register bank
package fault_status_pkg;

  // one-cycle fault events from the detectors around the bank
  typedef struct packed {
    logic outOv;
    logic outUv;
    logic ocFault;
    logic ocWarn;
    logic otFault;
    logic otWarn;
    logic badCmd;
    logic badData;
    logic pecFail;
    logic memFault;
    logic commOther;
    logic vinUv;
    logic dieOverheat;
  } fault_events_t;

  // a read request from the command layer
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
  } read_req_t;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    ANSWER = 2'b01
  } read_state_t;

endpackage : fault_status_pkg

// >>> sticky_flag_byte.sv
// one sticky status byte: hardware sets, a clear command empties it
`timescale 1ns/1ps
`include "fault_status_params.svh"

module sticky_flag_byte
  import fault_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] setMask,
  input wire logic [7:0] supported,
  input wire logic clear,
  output logic [7:0] flags
);

  logic [7:0] next_flags;

  // set wins over clear so an event in the clearing cycle is kept
  always_comb begin
    next_flags = clear ? 8'h00 : flags;
    next_flags = (next_flags | setMask) & supported;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= `FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

endmodule : sticky_flag_byte

// >>> summary_encoder.sv
// derives the summary byte and word high byte from the detail bytes
`timescale 1ns/1ps
`include "fault_status_params.svh"

module summary_encoder
  import fault_status_pkg::*;
(
  input wire logic [7:0] voutFlags,
  input wire logic [7:0] ioutFlags,
  input wire logic [7:0] tempFlags,
  input wire logic [7:0] commFlags,
  input wire logic convOff,
  input wire logic powerGood,
  input wire logic vinUvFlag,
  input wire logic vendorFlag,
  output logic [7:0] summaryLow,
  output logic [7:0] summaryHigh
);

  always_comb begin
    summaryLow = 8'h00;
    summaryHigh = 8'h00;
    summaryLow[`SB_OFF] = convOff;
    summaryLow[`SB_OV] = voutFlags[`VO_OV];
    summaryLow[`SB_OC] = ioutFlags[`IO_FAULT];
    summaryLow[`SB_INPUT_UNDERVOLTAGE_FLAG] = vinUvFlag;
    summaryLow[`SB_TEMP] = |tempFlags;
    summaryLow[`SB_CML] = |commFlags;
    // warnings with no summary bit of their own
    summaryLow[`SB_OTHER] = voutFlags[`VO_UV] | ioutFlags[`IO_WARN];
    summaryHigh[`SH_VOUT] = |voutFlags;
    summaryHigh[`SH_IOUT] = |ioutFlags;
    summaryHigh[`SH_VENDOR] = vendorFlag;
    summaryHigh[`SH_PGOOD] = powerGood;
  end

endmodule : summary_encoder

// >>> status_host_model.sv
// host-side model that issues status read commands and captures the answers
`timescale 1ns/1ps

module status_host_model
  import fault_status_pkg::*;
(
  input wire logic clk,
  output read_req_t readReq,
  input wire logic [15:0] readData,
  input wire logic readValid,
  input wire logic readWord,
  input wire logic cmdUnknown
);
  initial readReq = '0;

  // ---------------------------------------------
  // transfers
  // ---------------------------------------------
  // caller sits at a falling edge; request held through the taking edge, so reads run back to back
  task automatic xfer(input logic [7:0] cmd, output logic [15:0] data, output logic [2:0] flags);
    readReq = '{valid: 1'b1, cmd: cmd};
    @(negedge clk);
    data = readData;
    flags = {readValid, readWord, cmdUnknown};
  endtask : xfer

  // a released command bus does not keep showing the last code
  task automatic idle();
    readReq = '{valid: 1'b0, cmd: ~readReq.cmd};
    @(negedge clk);
  endtask : idle
endmodule : status_host_model

// >>> pmbus_fault_status_bank_tb.sv
// self-checking bench for the fault status register bank
`timescale 1ns/1ps
`include "fault_status_params.svh"

module pmbus_fault_status_bank_tb;
  import fault_status_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  read_req_t readReq;
  logic writeStrobe = 1'b0;
  logic clearFaults = 1'b0;
  fault_events_t events = '0;
  logic convEnabled = 1'b0;
  logic powerGood = 1'b0;
  logic [15:0] readData;
  logic readValid;
  logic readWord;
  logic cmdUnknown;
  integer mismatches = 0;
  integer num_checks = 0;
  integer seed = 89125;
  logic [7:0] vo, io, tf, cf, sb, sh, cmd;
  logic vin, die;
  logic [15:0] d, expData;
  logic [2:0] f;
  logic [7:0] cmds [7];

  always #20 clk = ~clk;

  pmbus_fault_status_bank pmbus_fault_status_bank_inst (.clk(clk), .rst(rst), .readReq(readReq),
    .writeStrobe(writeStrobe), .clearFaults(clearFaults), .events(events),
    .convEnabled(convEnabled), .powerGood(powerGood), .readData(readData),
    .readValid(readValid), .readWord(readWord), .cmdUnknown(cmdUnknown));

  status_host_model status_host_model_inst (.clk(clk), .readReq(readReq), .readData(readData),
    .readValid(readValid), .readWord(readWord), .cmdUnknown(cmdUnknown));

  // ---------------------------------------------
  // checking and closing
  // ---------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // 40 rounds of about ten cycles each; far more than that means a hang
  initial begin
    #(40 * 5000);
    mismatches++;
    report_and_stop();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {vo, io, tf, cf, vin, die} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 40; i++) begin
      // a reset in mid-run must empty every sticky byte again
      if (i == 20) begin
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        {vo, io, tf, cf, vin, die} = '0;
      end
      // first round leaves events idle so reset values are read back
      events = (i == 0) ? '0 : fault_events_t'($random(seed) & $random(seed) & $random(seed));
      clearFaults = (i > 0) && ($random(seed) % 4 == 0);
      writeStrobe = $random(seed);
      convEnabled = $random(seed);
      powerGood = $random(seed);
      if (clearFaults) begin
        {vo, io, tf, cf, vin, die} = '0;
      end
      vo = vo | {events.outOv, 2'b00, events.outUv, 4'h0};
      io = io | {events.ocFault, 1'b0, events.ocWarn, 5'h00};
      tf = tf | {events.otFault, events.otWarn, 6'h00};
      cf = cf | {events.badCmd, events.badData, events.pecFail, events.memFault, 2'b00,
        events.commOther, 1'b0};
      vin = vin | events.vinUv;
      die = die | events.dieOverheat;
      @(negedge clk);
      events = '0;
      clearFaults = 1'b0;
      sb = {1'b0, !convEnabled, vo[7], io[7], vin, |tf, |cf, vo[4] | io[5]};
      sh = {|vo, |io, 1'b0, die, powerGood, 3'b000};
      cmds = '{`CMD_SUMMARY_BYTE, `CMD_SUMMARY_WORD, `CMD_VOUT_FLAGS, `CMD_IOUT_FLAGS,
        `CMD_TEMP_FLAGS, `CMD_COMM_FLAGS, {1'b1, 7'($random(seed))}};
      for (int k = 0; k < 7; k++) begin
        cmd = cmds[k];
        status_host_model_inst.xfer(cmd, d, f);
        case (k)
          0: expData = {8'h00, sb};
          1: expData = {sh, sb};
          2: expData = {8'h00, vo};
          3: expData = {8'h00, io};
          4: expData = {8'h00, tf};
          5: expData = {8'h00, cf};
          default: expData = 16'h0000;
        endcase
        check("answer flags", {13'h0000, f}, {13'h0000, 1'b1, k == 1, k == 6});
        check("read data", d, expData);
      end
      status_host_model_inst.idle();
      cf[`CF_CMD] = 1'b1;
    end
    report_and_stop();
  end
endmodule : pmbus_fault_status_bank_tb
